/* File: rtl/cti_pkg.sv */
// shared constants and state types for the channel tag interlock pair
// Overview of operation
// [R01] channel answers status-in with service/command, or drops select
// [R02] status-in alone, no out tag except busy address
// [R03] status-in held until out tag; tag until fall
// [R04] short-busy status byte valid until select-out falls
// [R05] service-out only after recognizing service-in or status-in
// [R06] service-out on status/read frees bus-in, no bus-out data
// [R07] write service-out rises with byte on bus-out
// [R08] service-out held until in tag falls, alone
// [R09] service-in raised when byte ready or byte needed
// [R10] service-in alone, held until out tag rises
// [R11] late cyclic answer flags overrun, ends transfer
// [R12] overrun holds service-in to out tag, re-raise later
// [R13] suppress-out may change any time, passed to user
// [R14] clock-out and metering lines held permanently low
// [R15] at most one out tag, disconnect excepted
// [R16] one in tag, rising with out tags down
// [R17] in tag drops after responding out tag rises
// [R18] channel raises service/command out only replying in tag
// [R19] address-out for selection only with inbound lines quiet
// [R20] address-out held until selection answer or op-in drops
// [R21] select-out only while quiet; outbound ignored without op-out
// [R22] op-in only with op-out; held until sequence complete
// [R23] command-out answering status means stacked, present again later
package cti_pkg;
   localparam int CLK_NS = 50;
   localparam int T_ADR_SEL_NS = 400; // address-out lead before select-out
   localparam int ADR_SEL_CYC = (T_ADR_SEL_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_HOLD_DN_NS = 4000; // least hold-out down time
   localparam int HOLD_DN_CYC = (T_HOLD_DN_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_OVR_NS = 10000; // service-in wait before overrun
   localparam int OVR_CYC = T_OVR_NS / CLK_NS;
   localparam int SYNC_STAGES = 2;
   localparam logic [7:0] ST_BUSY = 8'h08;
   localparam logic [7:0] ST_MOD = 8'h40;
   localparam logic [7:0] ST_UNIT_CHECK = 8'h02;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   typedef enum logic [3:0] {
      CU_IDLE, CU_ADDR, CU_AIN, CU_AEND, CU_READY, CU_STAT, CU_SVC, CU_TEND, CU_BUSY, CU_DROP
   } cti_cu_st_t;
   typedef enum logic [3:0] {
      CH_IDLE, CH_ADDR, CH_SEL, CH_NODEV, CH_SBUSY, CH_AIN, CH_CMD, CH_RUN, CH_RESP, CH_DISC
   } cti_ch_st_t;
endpackage

/* File: rtl/cti_if.sv */
// tag and bus lines between channel and control unit
`timescale 1ns/1ps
interface cti_if;
   logic [7:0] bus_out;
   logic address_out, command_out, service_out, select_out, hold_out;
   logic operational_out, suppress_out, clock_out, metering_out;
   logic [7:0] bus_in;
   logic address_in, status_in, service_in, operational_in, select_in;
   logic request_in, metering_in;
   modport chan (
      output bus_out, address_out, command_out, service_out, select_out, hold_out,
      output operational_out, suppress_out, clock_out, metering_out,
      input bus_in, address_in, status_in, service_in, operational_in, select_in,
      input request_in, metering_in
   );
   modport cu (
      input bus_out, address_out, command_out, service_out, select_out, hold_out,
      input operational_out, suppress_out, clock_out, metering_out,
      output bus_in, address_in, status_in, service_in, operational_in, select_in,
      output request_in, metering_in
   );
endinterface

/* File: rtl/cti_cu.sv */
// control unit end of the tag interlock
`timescale 1ns/1ps
module cti_cu #(
   parameter logic [7:0] DEV_ADDR = 8'h10,
   parameter int OVR_CYCLES = cti_pkg::OVR_CYC
) (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   // link
   cti_if.cu lnk,
   // user side
   input wire logic i_busy,
   input wire logic i_read,
   input wire logic i_xfer_req,
   input wire logic [7:0] i_xfer_data,
   input wire logic i_status_req,
   input wire logic [7:0] i_status,
   output logic o_xfer_ack,
   output logic [7:0] o_xfer_data,
   output logic [7:0] o_cmd,
   output logic o_cmd_valid,
   output logic o_status_done,
   output logic o_stacked,
   output logic o_overrun,
   output logic o_unit_check,
   output logic o_suppress,
   output logic o_selected
);
   if (OVR_CYCLES < 1 || OVR_CYCLES > 65535) begin : g_bad
      $error("overrun count out of range");
   end

   // outbound lines through two flip-flops
   localparam int NB = 15;
   logic [NB-1:0] s1, s2, s3;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else if (i_ce) begin
         s1 <= {lnk.operational_out, lnk.suppress_out, lnk.select_out, lnk.address_out,
                lnk.command_out, lnk.service_out, lnk.hold_out, lnk.bus_out};
         s2 <= s1;
         s3 <= s2;
      end
   end

   // named outbound levels and edges
   wire op_out = s2[14];
   wire sel = s2[12] & s2[8] & op_out; // [R21]
   wire sel_rise = sel & ~(s3[12] & s3[8] & s3[14]);
   wire adr = s2[11] & op_out; // [R21]
   wire cmd = s2[10] & op_out;
   wire svc = s2[9] & op_out;
   wire [7:0] bo = s2[7:0];
   wire any_out = adr | cmd | svc | sel;
   wire resp = cmd | svc;
   wire match = adr & (bo == DEV_ADDR);

   // control unit state
   cti_pkg::cti_cu_st_t st, ret;
   logic ci, ending, pend, ovr, sel_in, drop_req;
   logic [15:0] ocnt;
   logic [7:0] bus_in, stat_byte;
   logic op_in, addr_in, stat_in, svc_in;
   wire ovr_hit = (ocnt == OVR_CYCLES[15:0]);

   // bus, tags and state
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st <= cti_pkg::CU_IDLE;
         ret <= cti_pkg::CU_IDLE;
         {ci, ending, pend, ovr, sel_in, drop_req} <= '0;
         {op_in, addr_in, stat_in, svc_in} <= '0;
         ocnt <= '0;
         bus_in <= cti_pkg::BYTE_ZERO;
         stat_byte <= cti_pkg::BYTE_ZERO;
         o_xfer_ack <= 1'b0;
         o_xfer_data <= cti_pkg::BYTE_ZERO;
         o_cmd <= cti_pkg::BYTE_ZERO;
         o_cmd_valid <= 1'b0;
         o_status_done <= 1'b0;
         o_stacked <= 1'b0;
         o_overrun <= 1'b0;
         o_unit_check <= 1'b0;
      end else if (i_ce) begin
         o_xfer_ack <= 1'b0;
         o_cmd_valid <= 1'b0;
         o_status_done <= 1'b0;
         sel_in <= (st == cti_pkg::CU_IDLE) & sel & ~match & ~(pend & ~adr);
         if (!op_out) begin
            // address, status, service and operational in down while the channel is not operational
            st <= cti_pkg::CU_IDLE; // [R22]
            {op_in, addr_in, stat_in, svc_in} <= '0; // [R22]
         end else if (adr && op_in && (st == cti_pkg::CU_READY || st == cti_pkg::CU_DROP)) begin
            // interface disconnect
            st <= cti_pkg::CU_IDLE; // [R22]
            op_in <= 1'b0; // [R22]
         end else begin
            unique case (st)
               cti_pkg::CU_IDLE: begin
                  if (sel_rise && match && i_busy) begin
                     bus_in <= cti_pkg::ST_BUSY | cti_pkg::ST_MOD; // [R04]
                     stat_in <= 1'b1; // [R02]
                     st <= cti_pkg::CU_BUSY;
                  end else if (sel_rise && match) begin
                     op_in <= 1'b1; // [R22]
                     ci <= 1'b0;
                     st <= cti_pkg::CU_ADDR;
                  end else if (sel_rise && !adr && (pend || i_status_req)) begin
                     op_in <= 1'b1; // [R22]
                     addr_in <= 1'b1; // [R16]
                     bus_in <= DEV_ADDR;
                     ci <= 1'b1;
                     stat_byte <= pend ? stat_byte : i_status;
                     st <= cti_pkg::CU_AIN;
                  end
               end
               cti_pkg::CU_ADDR: if (!adr) begin
                  bus_in <= DEV_ADDR;
                  addr_in <= 1'b1; // [R16]
                  st <= cti_pkg::CU_AIN;
               end
               cti_pkg::CU_AIN: if (cmd) begin
                  addr_in <= 1'b0; // [R17]
                  if (!ci) begin
                     o_cmd <= bo;
                     o_cmd_valid <= 1'b1;
                  end
                  st <= cti_pkg::CU_AEND;
               end
               cti_pkg::CU_AEND: if (!cmd) begin
                  if (!ci) begin
                     bus_in <= i_status; // initial status
                     stat_in <= 1'b1; // [R02]
                     ending <= 1'b0;
                     st <= cti_pkg::CU_STAT;
                  end else if (pend) begin
                     bus_in <= stat_byte; // [R23]
                     stat_in <= 1'b1; // [R02]
                     ending <= 1'b1;
                     st <= cti_pkg::CU_STAT;
                  end else begin
                     st <= cti_pkg::CU_READY;
                  end
               end
               cti_pkg::CU_READY: if (!any_out) begin
                  // in tags rise only with every out tag down
                  if (ovr || i_status_req) begin
                     bus_in <= ovr ? (i_status | cti_pkg::ST_UNIT_CHECK) : i_status; // [R11]
                     stat_in <= 1'b1; // [R16]
                     ending <= 1'b1;
                     st <= cti_pkg::CU_STAT;
                  end else if (i_xfer_req) begin
                     bus_in <= i_read ? i_xfer_data : cti_pkg::BYTE_ZERO;
                     svc_in <= 1'b1; // [R09]
                     ocnt <= '0;
                     st <= cti_pkg::CU_SVC;
                  end
               end
               cti_pkg::CU_STAT: if (resp) begin
                  stat_in <= 1'b0; // [R03]
                  if (cmd) begin
                     // status refused: keep it for a later request
                     pend <= 1'b1; // [R23]
                     stat_byte <= bus_in; // [R23]
                     o_stacked <= 1'b1; // [R23]
                     drop_req <= 1'b1;
                  end else begin
                     pend <= 1'b0; // [R06]
                     o_stacked <= 1'b0;
                     o_status_done <= 1'b1;
                     drop_req <= ending | ovr;
                  end
                  ovr <= 1'b0;
                  ret <= cti_pkg::CU_READY;
                  st <= cti_pkg::CU_TEND;
               end
               cti_pkg::CU_SVC: begin
                  if (!ovr && ovr_hit) begin
                     ovr <= 1'b1; // [R11]
                     o_overrun <= 1'b1; // [R11]
                     o_unit_check <= 1'b1; // [R11]
                  end else if (!ovr) begin
                     ocnt <= ocnt + 16'h0001;
                  end
                  if (resp || adr) begin
                     svc_in <= 1'b0; // [R10] [R12]
                     if (svc && !ovr) begin
                        o_xfer_ack <= 1'b1; // [R06]
                        o_xfer_data <= i_read ? o_xfer_data : bo; // [R07]
                     end
                     drop_req <= cmd; // stop ends the transfer
                     ret <= cti_pkg::CU_READY;
                     st <= cti_pkg::CU_TEND;
                  end
               end
               cti_pkg::CU_TEND: if (!resp) begin
                  // no new in tag before the answer has fallen
                  st <= drop_req ? cti_pkg::CU_DROP : ret; // [R12] [R03]
                  drop_req <= 1'b0;
               end
               cti_pkg::CU_DROP: if (!sel) begin
                  op_in <= 1'b0; // [R22]
                  st <= cti_pkg::CU_IDLE;
               end
               cti_pkg::CU_BUSY: if (!sel) begin
                  stat_in <= 1'b0; // [R03] [R17]
                  st <= cti_pkg::CU_IDLE;
               end
            endcase
         end
      end
   end

   // user-visible levels, request-in and unused metering line
   logic req_in, met_in;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_suppress <= 1'b0;
         o_selected <= 1'b0;
         req_in <= 1'b0;
         met_in <= 1'b0;
      end else if (i_ce) begin
         o_suppress <= s2[13]; // [R13]
         o_selected <= op_in;
         req_in <= (st == cti_pkg::CU_IDLE) & (pend | i_status_req);
         met_in <= 1'b0; // [R14]
      end
   end

   // link drive
   assign lnk.bus_in = bus_in;
   assign lnk.address_in = addr_in;
   assign lnk.status_in = stat_in;
   assign lnk.service_in = svc_in;
   assign lnk.operational_in = op_in;
   assign lnk.select_in = sel_in;
   assign lnk.request_in = req_in;
   assign lnk.metering_in = met_in;
endmodule

/* File: rtl/cti_chan.sv */
// channel end of the tag interlock
`timescale 1ns/1ps
module cti_chan #(
   parameter int HOLD_CYCLES = cti_pkg::HOLD_DN_CYC
) (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   // link
   cti_if.chan lnk,
   // user side
   input wire logic i_start,
   input wire logic [7:0] i_dev_addr,
   input wire logic [7:0] i_cmd,
   input wire logic i_read,
   input wire logic [7:0] i_wr_data,
   input wire logic i_stack,
   input wire logic i_stop,
   input wire logic i_disc,
   input wire logic i_suppress,
   output logic o_busy,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_wr_taken,
   output logic [7:0] o_status,
   output logic o_status_valid,
   output logic o_no_dev,
   output logic o_short_busy
);
   if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : g_bad
      $error("hold count out of range");
   end

   // inbound lines through two flip-flops
   logic [13:0] s1, s2, s3;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else if (i_ce) begin
         s1 <= {lnk.address_in, lnk.status_in, lnk.service_in, lnk.operational_in,
                lnk.select_in, lnk.request_in, lnk.bus_in};
         s2 <= s1;
         s3 <= s2;
      end
   end
   wire ain = s2[13];
   wire sin = s2[12];
   wire vin = s2[11];
   wire opi = s2[10];
   wire sli = s2[9];
   wire rqi = s2[8];
   wire sin_rise = sin & ~s3[12];
   wire vin_rise = vin & ~s3[11];
   wire quiet = ~sli & ~opi & ~sin; // [R19] [R21]

   cti_pkg::cti_ch_st_t st;
   logic ci, rd, adr, cmd, svc, sel, hold, op_out;
   logic [7:0] bus_out, cnt;

   // sequencing of the out tags
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st <= cti_pkg::CH_IDLE;
         {ci, rd, adr, cmd, svc, sel, hold, op_out} <= '0;
         bus_out <= cti_pkg::BYTE_ZERO;
         cnt <= '0;
         o_busy <= 1'b0;
         o_rd_data <= cti_pkg::BYTE_ZERO;
         {o_rd_valid, o_wr_taken, o_status_valid, o_no_dev, o_short_busy} <= '0;
         o_status <= cti_pkg::BYTE_ZERO;
      end else if (i_ce) begin
         op_out <= 1'b1;
         {o_rd_valid, o_wr_taken, o_status_valid, o_no_dev, o_short_busy} <= '0;
         if (cnt != '0 && !hold) begin
            cnt <= cnt - 8'h01;
         end
         o_busy <= (st != cti_pkg::CH_IDLE);
         unique case (st)
            cti_pkg::CH_IDLE: if (cnt == '0 && quiet && !sel) begin
               if (i_start) begin
                  bus_out <= i_dev_addr;
                  adr <= 1'b1; // [R19]
                  rd <= i_read;
                  ci <= 1'b0;
                  cnt <= cti_pkg::ADR_SEL_CYC[7:0];
                  st <= cti_pkg::CH_ADDR;
               end else if (rqi) begin
                  sel <= 1'b1; // [R21]
                  hold <= 1'b1;
                  ci <= 1'b1;
                  rd <= i_read;
                  st <= cti_pkg::CH_SEL;
               end
            end
            cti_pkg::CH_ADDR: if (cnt == '0 && quiet) begin
               sel <= 1'b1; // [R21]
               hold <= 1'b1;
               st <= cti_pkg::CH_SEL;
            end
            cti_pkg::CH_SEL: begin
               if (sli) begin
                  sel <= 1'b0;
                  hold <= 1'b0;
                  st <= cti_pkg::CH_NODEV;
               end else if (sin && !ci) begin
                  // short busy: dropping select frees the status byte
                  o_status <= s2[7:0];
                  o_status_valid <= 1'b1;
                  o_short_busy <= 1'b1;
                  sel <= 1'b0; // [R01]
                  hold <= 1'b0;
                  st <= cti_pkg::CH_SBUSY;
               end else if (opi) begin
                  adr <= 1'b0; // [R20]
                  st <= cti_pkg::CH_AIN;
               end
            end
            cti_pkg::CH_NODEV: if (!sli) begin
               adr <= 1'b0; // [R20]
               o_no_dev <= ~ci;
               st <= cti_pkg::CH_IDLE;
            end
            cti_pkg::CH_SBUSY: if (!sin) begin
               adr <= 1'b0; // [R20]
               st <= cti_pkg::CH_IDLE;
            end
            cti_pkg::CH_AIN: if (ain) begin
               bus_out <= ci ? cti_pkg::BYTE_ZERO : i_cmd;
               cmd <= 1'b1; // [R18] [R15]
               sel <= 1'b0;
               hold <= 1'b0;
               cnt <= HOLD_CYCLES[7:0];
               st <= cti_pkg::CH_CMD;
            end
            cti_pkg::CH_CMD: if (!ain) begin
               cmd <= 1'b0; // [R03]
               st <= cti_pkg::CH_RUN;
            end
            cti_pkg::CH_RUN: begin
               if (!opi) begin
                  st <= cti_pkg::CH_IDLE;
               end else if (i_disc) begin
                  adr <= 1'b1; // [R15]
                  st <= cti_pkg::CH_DISC;
               end else if (sin_rise) begin
                  o_status <= s2[7:0];
                  o_status_valid <= ~i_stack;
                  bus_out <= cti_pkg::BYTE_ZERO;
                  cmd <= i_stack; // [R01] [R23]
                  svc <= ~i_stack; // [R05] [R06]
                  st <= cti_pkg::CH_RESP;
               end else if (vin_rise) begin
                  bus_out <= (rd || i_stop) ? cti_pkg::BYTE_ZERO : i_wr_data; // [R07]
                  cmd <= i_stop; // [R10]
                  svc <= ~i_stop; // [R05] [R18]
                  o_rd_data <= s2[7:0];
                  o_rd_valid <= rd & ~i_stop; // [R06]
                  o_wr_taken <= ~rd & ~i_stop;
                  st <= cti_pkg::CH_RESP;
               end
            end
            cti_pkg::CH_RESP: if (!sin && !vin) begin
               cmd <= 1'b0; // [R03] [R08]
               svc <= 1'b0; // [R08]
               st <= cti_pkg::CH_RUN;
            end
            cti_pkg::CH_DISC: if (!opi) begin
               adr <= 1'b0; // [R20]
               cmd <= 1'b0;
               svc <= 1'b0;
               st <= cti_pkg::CH_IDLE;
            end
         endcase
      end
   end

   // unused lines held low, suppress passed straight on
   logic sup, clk_o, met_o;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         {sup, clk_o, met_o} <= '0;
      end else if (i_ce) begin
         sup <= i_suppress; // [R13]
         clk_o <= 1'b0; // [R14]
         met_o <= 1'b0; // [R14]
      end
   end

   // link drive
   assign lnk.bus_out = bus_out;
   assign lnk.address_out = adr;
   assign lnk.command_out = cmd;
   assign lnk.service_out = svc;
   assign lnk.select_out = sel;
   assign lnk.hold_out = hold;
   assign lnk.operational_out = op_out;
   assign lnk.suppress_out = sup;
   assign lnk.clock_out = clk_o;
   assign lnk.metering_out = met_o;
endmodule

/* File: bench/cti_checker.sv */
// interlock checks on the link between channel and control unit
`timescale 1ns/1ps
module cti_checker (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // outbound lines
   input wire logic [7:0] bus_out,
   input wire logic address_out,
   input wire logic command_out,
   input wire logic service_out,
   input wire logic select_out,
   input wire logic operational_out,
   input wire logic clock_out,
   input wire logic metering_out,
   // inbound lines
   input wire logic [7:0] bus_in,
   input wire logic address_in,
   input wire logic status_in,
   input wire logic service_in,
   input wire logic operational_in,
   input wire logic select_in,
   input wire logic metering_in
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // tag interlock properties
   property p_one_out; $onehot0({address_out, command_out, service_out}); endproperty
   property p_one_in; $onehot0({address_in, status_in, service_in}); endproperty
   property p_in_rise;
      $rose(service_in) || $rose(address_in) || $rose(status_in) |->
         !command_out && !service_out && (!address_out || status_in);
   endproperty
   property p_reply; $rose(service_out) || $rose(command_out) |-> $past(status_in || service_in || address_in);
   endproperty
   property p_in_fall; $fell(service_in) || $fell(address_in) |-> service_out || command_out; endproperty
   property p_st_fall; $fell(status_in) |-> service_out || command_out || !select_out; endproperty
   property p_out_hold; $fell(service_out) |-> $past(!status_in && !service_in); endproperty
   property p_st_bus; status_in && $past(status_in) && !service_out && !command_out |-> $stable(bus_in);
   endproperty
   property p_wr_bus; service_out && $past(service_out) |-> $stable(bus_out); endproperty
   property p_unused; !clock_out && !metering_out && !metering_in; endproperty
   property p_adr_rise; $rose(address_out) |-> $past(!select_in && !operational_in && !status_in && !select_out);
   endproperty
   property p_sel_rise; $rose(select_out) |-> $past(!operational_in && !select_in); endproperty
   property p_op_rise; $rose(operational_in) |-> operational_out; endproperty
   a_one_out: assert property (p_one_out) else $error("two out tags up");
   a_one_in: assert property (p_one_in) else $error("two in tags up");
   a_in_rise: assert property (p_in_rise) else $error("in tag rose with out tag up");
   a_reply: assert property (p_reply) else $error("out tag rose without in tag");
   a_in_fall: assert property (p_in_fall) else $error("in tag fell without reply");
   a_st_fall: assert property (p_st_fall) else $error("status in fell early");
   a_out_hold: assert property (p_out_hold) else $error("service out fell early");
   a_st_bus: assert property (p_st_bus) else $error("status byte changed");
   a_wr_bus: assert property (p_wr_bus) else $error("bus out changed under service out");
   a_unused: assert property (p_unused) else $error("unused line raised");
   a_adr_rise: assert property (p_adr_rise) else $error("address out rose on busy link");
   a_sel_rise: assert property (p_sel_rise) else $error("select out rose on busy link");
   a_op_rise: assert property (p_op_rise) else $error("operational in without operational out");
   // main scenario coverage
   c_data: cover property ($rose(service_out) && service_in);
   c_sbusy: cover property (status_in && !operational_in);
   c_nodev: cover property ($rose(select_in));
endmodule

/* File: bench/tb_channel_tag_interlock.sv */
// self-checking bench joining channel and control unit ends
`timescale 1ns/1ps
module tb_channel_tag_interlock;
   logic clk = 1'b0, rst = 1'b1, ce_ch = 1'b1, start = 1'b0, rd = 1'b0, sup = 1'b0;
   logic busy = 1'b0, xreq = 1'b0, sreq = 1'b0, ovr = 1'b0, ce_cu = 1'b1, stk_req = 1'b0;
   logic [7:0] adr = 8'h10, cmd = 8'h00, wd = 8'h00, xd = 8'h00, st = 8'h00;
   logic ch_busy, rd_v, wr_t, st_v, no_dev, sb, ack, cmd_v, sdone, stk, ovf, uchk, osup, osel;
   logic [7:0] rdd, ost, oxd, ocmd;
   logic [7:0] exp_q[$];
   int num_errors = 0, num_checks = 0, seed = 45903;
   cti_if lnk();
   always #25 clk = ~clk;
   cti_cu #(.OVR_CYCLES(20)) cti_cu_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce_cu),
      .lnk(lnk), .i_busy(busy), .i_read(rd), .i_xfer_req(xreq), .i_xfer_data(xd), .i_status_req(sreq),
      .i_status(st), .o_xfer_ack(ack), .o_xfer_data(oxd), .o_cmd(ocmd), .o_cmd_valid(cmd_v),
      .o_status_done(sdone), .o_stacked(stk), .o_overrun(ovf), .o_unit_check(uchk), .o_suppress(osup),
      .o_selected(osel));
   cti_chan #(.HOLD_CYCLES(4)) cti_chan_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce_ch), .lnk(lnk),
      .i_start(start), .i_dev_addr(adr), .i_cmd(cmd), .i_read(rd), .i_wr_data(wd), .i_stack(stk_req),
      .i_stop(1'b0), .i_disc(1'b0), .i_suppress(sup), .o_busy(ch_busy), .o_rd_data(rdd), .o_rd_valid(rd_v),
      .o_wr_taken(wr_t), .o_status(ost), .o_status_valid(st_v), .o_no_dev(no_dev), .o_short_busy(sb));
   cti_checker cti_checker_inst (.i_clk_sys(clk), .i_rst(rst), .bus_out(lnk.bus_out),
      .address_out(lnk.address_out), .command_out(lnk.command_out), .service_out(lnk.service_out),
      .select_out(lnk.select_out), .operational_out(lnk.operational_out), .clock_out(lnk.clock_out),
      .metering_out(lnk.metering_out), .bus_in(lnk.bus_in), .address_in(lnk.address_in),
      .status_in(lnk.status_in), .service_in(lnk.service_in), .operational_in(lnk.operational_in),
      .select_in(lnk.select_in), .metering_in(lnk.metering_in));
   // verdict and end of run
   task finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // single comparison point
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // oldest note against a result
   task take(input logic [7:0] seen, input string what);
      chk(seen, (exp_q.size() > 0) ? exp_q.pop_front() : ~seen, what);
   endtask
   // condition selector for bounded waits
   function logic see(input int k);
      case (k)
         0: see = osel;
         1: see = ack;
         2: see = !osel;
         3: see = !ch_busy;
         4: see = sb;
         5: see = no_dev;
         7: see = lnk.service_in;
         8: see = sdone;
         9: see = stk;
         default: see = ovf;
      endcase
   endfunction
   task wt(input int k);
      int n;
      for (n = 0; n < 500 && see(k) !== 1'b1; n++) @(negedge clk);
      chk({7'h00, see(k)}, 8'h01, "handshake");
      if (see(k) !== 1'b1) finish_test;
   endtask
   // one selection with one byte and ending status, stacked once if s
   task op(input logic r, input logic o, input logic s);
      @(negedge clk);
      rd = r;
      ovr = o;
      adr = 8'h10;
      cmd = 8'($random(seed));
      wd = 8'($random(seed));
      xd = 8'($random(seed));
      st = 8'($random(seed)) & 8'hb5;
      sup = 1'($random(seed));
      exp_q.push_back(cmd);
      exp_q.push_back(st);
      if (!r) exp_q.push_back(wd);
      if (!o) exp_q.push_back(r ? xd : wd);
      exp_q.push_back(o ? (st | cti_pkg::ST_UNIT_CHECK) : st);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wt(0);
      xreq = 1'b1;
      wt(7);
      ce_ch = !o;
      wt(o ? 6 : 1);
      if (o) chk({6'h00, ovf, uchk}, 8'h03, "overrun flags");
      ce_ch = 1'b1;
      xreq = 1'b0;
      sreq = 1'b1;
      stk_req = s;
      if (s) wt(9);
      stk_req = 1'b0;
      wt(8);
      sreq = 1'b0;
      wt(2);
      wt(3);
      chk({7'h00, osup}, {7'h00, sup}, "suppress");
   endtask
   // results compared as they appear, between edges
   always @(negedge clk) begin
      if (!rst && cmd_v) take(ocmd, "command");
      if (!rst && st_v) take(ost, "status");
      if (!rst && rd_v) take(rdd, "read byte");
      if (!rst && wr_t) take(lnk.bus_out, "write byte out");
      if (!rst && ack && !rd && !ovr) take(oxd, "write byte");
   end
   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 6; i++) op(1'(i), 1'b0, i == 3);
      busy = 1'b1;
      exp_q.push_back(cti_pkg::ST_BUSY | cti_pkg::ST_MOD);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wt(4);
      busy = 1'b0;
      ce_cu = 1'b0;
      repeat (4) @(negedge clk);
      ce_cu = 1'b1;
      wt(3);
      chk(8'(exp_q.size()), 8'h00, "notes left");
      adr = 8'h11;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wt(5);
      wt(3);
      op(1'b0, 1'b1, 1'b0);
      finish_test;
   end
endmodule
